// ### core/drive_ctrl_pkg.sv
/*
 * Package for the drive control word decoder: field layouts of the two
 * cyclic control words, telegram numbers, stop-sequence states and reset
 * values.
 * Assumes a single clock domain and no other users of these names.
 */
package drive_ctrl_pkg;

    // ************************************************************
    // Control word one, bit 15 down to bit 0
    // ************************************************************
    typedef struct packed {
        logic cmd_set_bit0;     // Bit 15
        logic pot_lower;        // Bit 14
        logic pot_raise;        // Bit 13
        logic rsvd12;           // Bit 12
        logic setpoint_invert;  // Bit 11
        logic control_by_plc;   // Bit 10
        logic rsvd9;            // Bit 9
        logic rsvd8;            // Bit 8
        logic fault_ack;        // Bit 7
        logic setpoint_enable;  // Bit 6
        logic rfg_continue;     // Bit 5
        logic rfg_enable;       // Bit 4
        logic operation_enable; // Bit 3
        logic quick_stop_n;     // Bit 2
        logic coast_stop_n;     // Bit 1
        logic ramp_stop_n;      // Bit 0
    } word_one_t;

    // ************************************************************
    // Control word two, bit 15 down to bit 0
    // ************************************************************
    typedef struct packed {
        logic [3:0] sign_of_life; // Bits 15..12, bit 12 least significant
        logic [9:0] rsvd;         // Bits 11..2
        logic [1:0] drive_set;    // Bits 1..0, bit 0 least significant
    } word_two_t;

    // ************************************************************
    // Decoded ramp-function-generator controls
    // ************************************************************
    typedef struct packed {
        logic force_zero; // Output forced to zero setpoint
        logic freeze;     // Output held at present value
    } rfg_ctrl_t;

    // ************************************************************
    // Stop-sequence states
    // ************************************************************
    typedef enum logic [1:0] {
        ST_INHIBIT   = 2'b00,
        ST_RUN       = 2'b01,
        ST_RAMP_DOWN = 2'b10,
        ST_QUICK     = 2'b11
    } drive_state_t;

    // Telegram numbers that change the meaning of bits 13..15
    localparam logic [9:0]  TELEGRAM_STD     = 10'h001;
    localparam logic [9:0]  TELEGRAM_POT     = 10'h160;
    localparam logic [9:0]  TELEGRAM_CMD_SET = 10'h014;

    // Values after reset: all stop commands active, nothing enabled; then the setpoint limits used by inversion
    localparam logic [15:0] WORD_ONE_RESET   = 16'h0000;
    localparam logic [15:0] WORD_TWO_RESET   = 16'h0000;
    localparam logic [15:0] SETPOINT_RESET   = 16'h0000;
    localparam logic [15:0] SETPOINT_MAX_POS = 16'h7fff;
    localparam logic [15:0] SETPOINT_MIN_NEG = 16'h8000;

endpackage

// ### core/drive_control_word_decoder.sv
/*
 * Drive control word decoder: takes the two cyclic control words and the
 * speed setpoint from the fieldbus master, gates them by the PLC-control
 * bit and turns them into pulse, contactor, ramp generator, fault
 * acknowledge, potentiometer and parameter-set commands.
 * Assumes all inputs synchronous to CLK, words valid while WORD_VALID is
 * high, and RAMP_AT_ZERO reported by the ramp-function generator.
 */
// Overview of operation
// R1: Bit0 low ramps down then inhibits; rise enables
// R2: Coast stop is AND of two sources
// R3: Bit2 low quick-stops then inhibits pulses
// R4: Bit3 low inhibits pulses, ready stays set
// R5: Bit3 high enables pulses, ramps to setpoint
// R6: Bit4 low forces ramp generator output zero
// R7: Bit5 low freezes ramp generator output
// R8: Bit6 high passes speed setpoint through
// R9: Bit6 low zeroes ramp generator input
// R10: Rising edge of any acknowledge source clears faults
// R11: Bit10 low means words are ignored
// R12: Master raises bit10 only after request-control status
// R13: Bit11 high inverts the setpoint sign
// R14: Bits13/14 are potentiometer only for telegrams 1,352
// R15: Bit15 selects command set only with telegram 20
// R16: Word two bits 1..0 select drive set
// R17: Word two bits 15..12 are master sign-of-life
// R18: Reserved bits have no effect
// R19: Raise and lower equal holds the potentiometer
`timescale 1ns/1ps
`default_nettype none

module drive_control_word_decoder (
    // Clock and reset
    input  wire logic                        CLK,
    input  wire logic                        RST_B,
    // Cyclic process data from the master
    input  wire logic                        WORD_VALID,
    input  wire drive_ctrl_pkg::word_one_t   WORD_ONE,
    input  wire drive_ctrl_pkg::word_two_t   WORD_TWO,
    input  wire logic [15:0]                 SPEED_SETPOINT,
    input  wire logic [9:0]                  TELEGRAM_SELECTOR,
    // Further command sources inside the drive
    input  wire logic                        COAST_STOP_SOURCE_B,
    input  wire logic                        FAULT_ACK_SOURCE_B,
    input  wire logic                        FAULT_ACK_SOURCE_C,
    input  wire logic                        RAMP_AT_ZERO,
    // Power section commands
    output logic                             PULSE_ENABLE,
    output logic                             LINE_CONTACTOR_CLOSE,
    output logic                             READY_FOR_OPERATION,
    output drive_ctrl_pkg::drive_state_t     STOP_STATE,
    // Ramp-function generator
    output drive_ctrl_pkg::rfg_ctrl_t        RFG_CTRL,
    output logic [15:0]                      RFG_SETPOINT,
    // Faults, potentiometer and parameter sets
    output logic                             FAULT_ACK,
    output logic                             POT_RAISE,
    output logic                             POT_LOWER,
    output logic                             CMD_SET_SELECT,
    output logic [1:0]                       DRIVE_SET_SELECT,
    output logic [3:0]                       MASTER_SIGN_OF_LIFE,
    // Status toward the master
    output logic                             CONTROL_REQUEST,
    output logic                             CONTROL_ACCEPTED
);

    // ************************************************************
    // Evaluated words
    // ************************************************************
    // Copies of the accepted words; every decode but CONTROL_ACCEPTED reads these,
    // so those outputs move together two edges after a take
    drive_ctrl_pkg::word_one_t    word_one_q;
    drive_ctrl_pkg::word_two_t    word_two_q;
    logic [15:0]                  setpoint_q;
    logic                         accepted_q;
    logic                         ramp_stop_prev_q;
    logic                         ack_prev_q;
    logic                         ack_b_prev_q;
    logic                         ack_c_prev_q;
    drive_ctrl_pkg::drive_state_t state_q;
    drive_ctrl_pkg::drive_state_t state_d;
    logic                         coast_ok;
    logic                         switch_on_edge;
    logic                         pot_telegram;
    logic [15:0]                  signed_setpoint;

    // Words are taken only while the PLC-control bit is set; otherwise the
    // last evaluated command stays in force
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            word_one_q <= drive_ctrl_pkg::word_one_t'(drive_ctrl_pkg::WORD_ONE_RESET);
            word_two_q <= drive_ctrl_pkg::word_two_t'(drive_ctrl_pkg::WORD_TWO_RESET);
            setpoint_q <= drive_ctrl_pkg::SETPOINT_RESET;
        end else if (WORD_VALID && WORD_ONE.control_by_plc) begin // R11
            word_one_q <= WORD_ONE;
            word_two_q <= WORD_TWO;
            setpoint_q <= SPEED_SETPOINT;
        end
    end

    // PLC-control bit itself is always seen, so the master can hand over
    // Kept apart so the master sees its hand-over one edge after the word, not two
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            accepted_q <= 1'b0;
        end else if (WORD_VALID) begin
            accepted_q <= WORD_ONE.control_by_plc; // R11
        end
    end

    // The drive is always able to take control; master waits for this
    // Nothing here can refuse control, so it never drops
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            CONTROL_REQUEST <= 1'b0;
        end else begin
            CONTROL_REQUEST <= 1'b1; // R12
        end
    end

    assign CONTROL_ACCEPTED = accepted_q;

    // ************************************************************
    // Stop sequence
    // ************************************************************

    // Coast stop needs both sources high
    // Source B bypasses bit 10, so coasting still works
    // while the master has handed control away
    assign coast_ok       = word_one_q.coast_stop_n & COAST_STOP_SOURCE_B; // R2
    assign switch_on_edge = word_one_q.ramp_stop_n & ~ramp_stop_prev_q;    // R1

    // Edge memory for switch-on
    // Resets low: a first word with bit 0 high is an edge
    // Only the edge restarts, so a held bit 0 cannot rearm
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ramp_stop_prev_q <= 1'b0;
        end else begin
            ramp_stop_prev_q <= word_one_q.ramp_stop_n;
        end
    end

    // Coast stop beats quick stop beats ramp stop
    // RAMP_AT_ZERO ends both stop ramps; the ramp itself
    // runs in the external generator, not in this block
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            drive_ctrl_pkg::ST_INHIBIT: begin
                // Only a fresh switch-on edge restarts, never a held level
                if (switch_on_edge && coast_ok && word_one_q.quick_stop_n) begin
                    state_d = drive_ctrl_pkg::ST_RUN; // R1
                end
            end
            drive_ctrl_pkg::ST_RUN: begin
                if (!coast_ok) begin
                    state_d = drive_ctrl_pkg::ST_INHIBIT; // R2
                end else if (!word_one_q.quick_stop_n) begin
                    state_d = drive_ctrl_pkg::ST_QUICK; // R3
                end else if (!word_one_q.ramp_stop_n) begin
                    state_d = drive_ctrl_pkg::ST_RAMP_DOWN; // R1
                end
            end
            drive_ctrl_pkg::ST_RAMP_DOWN: begin
                if (!coast_ok || RAMP_AT_ZERO) begin
                    state_d = drive_ctrl_pkg::ST_INHIBIT; // R1
                end else if (!word_one_q.quick_stop_n) begin
                    state_d = drive_ctrl_pkg::ST_QUICK; // R3
                end
            end
            drive_ctrl_pkg::ST_QUICK: begin
                if (!coast_ok || RAMP_AT_ZERO) begin
                    state_d = drive_ctrl_pkg::ST_INHIBIT; // R3
                end
            end
        endcase
    end

    // State register
    // Reset lands in inhibit: no pulses before a switch-on
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= drive_ctrl_pkg::ST_INHIBIT;
        end else begin
            state_q <= state_d;
        end
    end

    // Power outputs; bit 3 gates pulses but leaves readiness alone
    // Built from state_d so they line up with STOP_STATE
    // instead of trailing it by one edge
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            PULSE_ENABLE         <= 1'b0;
            LINE_CONTACTOR_CLOSE <= 1'b0;
            READY_FOR_OPERATION  <= 1'b0;
        end else begin
            PULSE_ENABLE         <= (state_d != drive_ctrl_pkg::ST_INHIBIT)
                                    && word_one_q.operation_enable; // R4 R5
            LINE_CONTACTOR_CLOSE <= (state_d != drive_ctrl_pkg::ST_INHIBIT); // R1 R2 R3
            READY_FOR_OPERATION  <= (state_d != drive_ctrl_pkg::ST_INHIBIT); // R4
        end
    end

    assign STOP_STATE = state_q;

    // ************************************************************
    // Ramp-function generator
    // ************************************************************

    // Inversion saturates so the most negative value cannot wrap to itself
    // Trade-off: one count of error at full negative scale
    // beats a sign flip that would drive the wrong way
    always_comb begin
        if (!word_one_q.setpoint_invert) begin
            signed_setpoint = setpoint_q;
        end else if (setpoint_q == drive_ctrl_pkg::SETPOINT_MIN_NEG) begin
            signed_setpoint = drive_ctrl_pkg::SETPOINT_MAX_POS; // R13
        end else begin
            signed_setpoint = 16'(~setpoint_q + 16'h0001); // R13
        end
    end

    // Quick stop forces the input to zero so the generator brakes hard
    // Setpoint passes only in RUN; both stop states hold
    // the generator input at zero while it winds down
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RFG_SETPOINT <= drive_ctrl_pkg::SETPOINT_RESET;
            RFG_CTRL     <= '{force_zero: 1'b1, freeze: 1'b0};
        end else begin
            if (word_one_q.setpoint_enable && state_d == drive_ctrl_pkg::ST_RUN) begin
                RFG_SETPOINT <= signed_setpoint; // R8
            end else begin
                RFG_SETPOINT <= drive_ctrl_pkg::SETPOINT_RESET; // R9
            end
            RFG_CTRL.force_zero <= ~word_one_q.rfg_enable;   // R6
            RFG_CTRL.freeze     <= ~word_one_q.rfg_continue; // R7
        end
    end

    // ************************************************************
    // Fault acknowledge
    // ************************************************************

    // Edge memories for the three acknowledge sources
    // Reset low: an external source already high at release
    // gives one acknowledge pulse on the first edge
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ack_prev_q   <= 1'b0;
            ack_b_prev_q <= 1'b0;
            ack_c_prev_q <= 1'b0;
        end else begin
            ack_prev_q   <= word_one_q.fault_ack;
            ack_b_prev_q <= FAULT_ACK_SOURCE_B;
            ack_c_prev_q <= FAULT_ACK_SOURCE_C;
        end
    end

    // One-cycle pulse on any rising edge; a held level acknowledges once
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            FAULT_ACK <= 1'b0;
        end else begin
            FAULT_ACK <= (word_one_q.fault_ack && !ack_prev_q)
                         || (FAULT_ACK_SOURCE_B && !ack_b_prev_q)
                         || (FAULT_ACK_SOURCE_C && !ack_c_prev_q); // R10
        end
    end

    // ************************************************************
    // Telegram-dependent bits and word two
    // ************************************************************
    // Telegram number is a static level, used unregistered;
    // a change acts at the next edge, one edge sooner than a change of the words
    assign pot_telegram = (TELEGRAM_SELECTOR == drive_ctrl_pkg::TELEGRAM_STD)
                          || (TELEGRAM_SELECTOR == drive_ctrl_pkg::TELEGRAM_POT); // R14

    // Reserved bits are never read, so they cannot steer anything
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            POT_RAISE           <= 1'b0;
            POT_LOWER           <= 1'b0;
            CMD_SET_SELECT      <= 1'b0;
            DRIVE_SET_SELECT    <= 2'h0;
            MASTER_SIGN_OF_LIFE <= 4'h0;
        end else begin
            // Both equal means neither moves, so the pot holds
            POT_RAISE           <= pot_telegram && word_one_q.pot_raise
                                   && !word_one_q.pot_lower; // R14 R19
            POT_LOWER           <= pot_telegram && word_one_q.pot_lower
                                   && !word_one_q.pot_raise; // R14 R19
            CMD_SET_SELECT      <= (TELEGRAM_SELECTOR == drive_ctrl_pkg::TELEGRAM_CMD_SET)
                                   && word_one_q.cmd_set_bit0; // R15
            DRIVE_SET_SELECT    <= word_two_q.drive_set;     // R16 R18
            MASTER_SIGN_OF_LIFE <= word_two_q.sign_of_life;  // R17
        end
    end

endmodule // drive_control_word_decoder

`default_nettype wire

// ### bench/fieldbus_master_model.sv
/* Fieldbus master model: sends the cyclic control words and setpoint.
   Assumes one clock and the decoder's CONTROL_REQUEST status. */
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_model (
    // Clock and status from the drive
    input  wire logic                     CLK,
    input  wire logic                     CONTROL_REQUEST,
    // Cyclic process data
    output var logic                      WORD_VALID,
    output var drive_ctrl_pkg::word_one_t WORD_ONE,
    output var drive_ctrl_pkg::word_two_t WORD_TWO,
    output var logic [15:0]               SPEED_SETPOINT
);
    // ********
    // Telegram source
    // ********
    // Idle words keep every stop command active
    initial begin
        WORD_VALID = 1'b0;
        WORD_ONE = '0;
        WORD_TWO = '0;
        SPEED_SETPOINT = 16'h0000;
    end
    // Words stand as a level, as a cyclic telegram repeats them
    task automatic send(input logic [15:0] w1, input logic [15:0] w2, input logic [15:0] sp);
        int n = 0;
        while (w1[10] && CONTROL_REQUEST !== 1'b1 && n < 100) begin
            @(posedge CLK);
            n++;
        end
        @(posedge CLK);
        WORD_VALID <= 1'b1;
        WORD_ONE <= w1;
        WORD_TWO <= w2;
        SPEED_SETPOINT <= sp;
    endtask
endmodule // fieldbus_master_model
`default_nettype wire

// ### bench/drive_control_word_decoder_chk.sv
/* Checker for the control word decoder, bound to its top module.
   Assumes the decoder's two-edge answer after a taken word. */
`timescale 1ns/1ps
`default_nettype none
module drive_control_word_decoder_chk (
    // Clock, reset and inputs
    input wire logic                         CLK,
    input wire logic                         RST_B,
    input wire logic                         WORD_VALID,
    input wire drive_ctrl_pkg::word_one_t    WORD_ONE,
    input wire drive_ctrl_pkg::word_two_t    WORD_TWO,
    input wire logic                         COAST_STOP_SOURCE_B,
    input wire logic                         FAULT_ACK_SOURCE_B,
    // Outputs watched
    input wire logic                         PULSE_ENABLE,
    input wire logic                         READY_FOR_OPERATION,
    input wire drive_ctrl_pkg::drive_state_t STOP_STATE,
    input wire drive_ctrl_pkg::rfg_ctrl_t    RFG_CTRL,
    input wire logic [15:0]                  RFG_SETPOINT,
    input wire logic                         FAULT_ACK,
    input wire logic [1:0]                   DRIVE_SET_SELECT,
    input wire logic [3:0]                   MASTER_SIGN_OF_LIFE
);
    // ********
    // Properties
    // ********
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // Unchanged words make the answer independent of the exact latency
    sequence s_taken;
        WORD_VALID && WORD_ONE.control_by_plc && $stable(WORD_ONE) && $stable(WORD_TWO);
    endsequence
    sequence s_refused;
        WORD_VALID && !WORD_ONE.control_by_plc;
    endsequence
    AST_PULSE_STATE: assert property (PULSE_ENABLE |-> STOP_STATE != drive_ctrl_pkg::ST_INHIBIT)
        else $error("pulses enabled while inhibited");
    AST_READY: assert property (READY_FOR_OPERATION == (STOP_STATE != drive_ctrl_pkg::ST_INHIBIT))
        else $error("ready flag does not follow state");
    AST_STOP_ZERO: assert property (STOP_STATE[1] |-> RFG_SETPOINT == 16'h0000)
        else $error("ramp input not zero while stopping");
    AST_COAST: assert property (!COAST_STOP_SOURCE_B [*3] |=> !PULSE_ENABLE)
        else $error("pulses kept during coast stop");
    AST_ACK_B: assert property ($rose(FAULT_ACK_SOURCE_B) |-> ##[1:3] FAULT_ACK)
        else $error("second acknowledge source ignored");
    AST_FORCE_ZERO: assert property (s_taken [*3] ##0 !WORD_ONE.rfg_enable |=> RFG_CTRL.force_zero)
        else $error("ramp generator not forced to zero");
    AST_FREEZE: assert property (s_taken [*3] |=> RFG_CTRL.freeze == !$past(WORD_ONE.rfg_continue))
        else $error("freeze does not follow word");
    AST_IGNORE: assert property (s_refused [*4] |=> $stable(DRIVE_SET_SELECT) && $stable(MASTER_SIGN_OF_LIFE))
        else $error("refused word changed outputs");
    AST_SIGN_LIFE: assert property (s_taken [*3] |=> MASTER_SIGN_OF_LIFE == $past(WORD_TWO.sign_of_life))
        else $error("sign of life mismatch");
    AST_DRIVE_SET: assert property (s_taken [*3] |=> DRIVE_SET_SELECT == $past(WORD_TWO.drive_set))
        else $error("drive set mismatch");
endmodule // drive_control_word_decoder_chk
bind drive_control_word_decoder drive_control_word_decoder_chk chk (
    .CLK(CLK), .RST_B(RST_B), .WORD_VALID(WORD_VALID), .WORD_ONE(WORD_ONE), .WORD_TWO(WORD_TWO),
    .COAST_STOP_SOURCE_B(COAST_STOP_SOURCE_B), .FAULT_ACK_SOURCE_B(FAULT_ACK_SOURCE_B),
    .PULSE_ENABLE(PULSE_ENABLE), .READY_FOR_OPERATION(READY_FOR_OPERATION), .STOP_STATE(STOP_STATE),
    .RFG_CTRL(RFG_CTRL), .RFG_SETPOINT(RFG_SETPOINT), .FAULT_ACK(FAULT_ACK),
    .DRIVE_SET_SELECT(DRIVE_SET_SELECT), .MASTER_SIGN_OF_LIFE(MASTER_SIGN_OF_LIFE));
`default_nettype wire

// ### bench/drive_control_word_decoder_tb_top.sv
/* Self-checking bench for the control word decoder.
   Assumes the master model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module drive_control_word_decoder_tb_top;
    logic clk, rst_b, vld, coast_b, ack_b, ack_c, at_zero, pulse, cont, ready, ack, raise, lower, cset, req, acc;
    logic [9:0] tg;
    logic [15:0] sp, rsp;
    logic [1:0] dset;
    logic [3:0] sol;
    drive_ctrl_pkg::word_one_t w1;
    drive_ctrl_pkg::word_two_t w2;
    drive_ctrl_pkg::drive_state_t st;
    drive_ctrl_pkg::rfg_ctrl_t rfg;
    int err_count, total_checks;
    // ********
    // Structure
    // ********
    fieldbus_master_model master (.CLK(clk), .CONTROL_REQUEST(req), .WORD_VALID(vld), .WORD_ONE(w1),
        .WORD_TWO(w2), .SPEED_SETPOINT(sp));
    drive_control_word_decoder dut (.CLK(clk), .RST_B(rst_b), .WORD_VALID(vld), .WORD_ONE(w1), .WORD_TWO(w2),
        .SPEED_SETPOINT(sp), .TELEGRAM_SELECTOR(tg), .COAST_STOP_SOURCE_B(coast_b), .FAULT_ACK_SOURCE_B(ack_b),
        .FAULT_ACK_SOURCE_C(ack_c), .RAMP_AT_ZERO(at_zero), .PULSE_ENABLE(pulse), .LINE_CONTACTOR_CLOSE(cont),
        .READY_FOR_OPERATION(ready), .STOP_STATE(st), .RFG_CTRL(rfg), .RFG_SETPOINT(rsp), .FAULT_ACK(ack),
        .POT_RAISE(raise), .POT_LOWER(lower), .CMD_SET_SELECT(cset), .DRIVE_SET_SELECT(dset),
        .MASTER_SIGN_OF_LIFE(sol), .CONTROL_REQUEST(req), .CONTROL_ACCEPTED(acc));
    // Clock of 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ********
    // Helpers
    // ********
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // Five edges cover the two-edge answer with margin
    task automatic put(input logic [15:0] a, input logic [15:0] b, input logic [15:0] s);
        master.send(a, b, s);
        repeat (5) @(posedge clk);
        #1;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic count_ack(output int n);
        n = 0;
        repeat (6) begin
            @(posedge clk);
            #1;
            n += int'(ack === 1'b1);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_switch_on();
        put(16'h047f, 16'h0000, 16'h0100);
        check("state", 16'(st), 16'(drive_ctrl_pkg::ST_RUN));
        check("pulse", 16'(pulse), 16'h0001);
        check("contactor", 16'(cont), 16'h0001);
        check("accepted", 16'(acc), 16'h0001);
        check("ramp input", rsp, 16'h0100);
        check("rfg ctrl", 16'(rfg), 16'h0000);
        put(16'h0477, 16'h0000, 16'h0100);
        check("pulse", 16'(pulse), 16'h0000);
        check("ready", 16'(ready), 16'h0001);
    endtask
    task automatic t_ramp_gen();
        put(16'h046f, 16'h0000, 16'h0100);
        check("rfg ctrl", 16'(rfg), 16'h0002);
        put(16'h045f, 16'h0000, 16'h0100);
        check("rfg ctrl", 16'(rfg), 16'h0001);
        put(16'h043f, 16'h0000, 16'h0100);
        check("ramp input", rsp, 16'h0000);
        put(16'h0c7f, 16'h0000, 16'h0100);
        check("ramp input", rsp, 16'hff00);
        put(16'h0c7f, 16'h0000, 16'h8000);
        check("ramp input", rsp, 16'h7fff);
    endtask
    // Bit 7, then the two further sources; each held high gives one pulse
    task automatic t_fault_ack();
        int n;
        master.send(16'h04ff, 16'h0000, 16'h0100);
        count_ack(n);
        check("ack pulses", 16'(n), 16'h0001);
        @(posedge clk) ack_b <= 1'b1;
        count_ack(n);
        check("ack pulses b", 16'(n), 16'h0001);
        @(posedge clk) ack_c <= 1'b1;
        count_ack(n);
        check("ack pulses c", 16'(n), 16'h0001);
    endtask
    task automatic t_pot_sets();
        logic [9:0] tel [3] = '{10'h001, 10'h160, 10'h014};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) tg <= tel[i];
            put(16'ha47f, 16'h0000, 16'h0100);
            check("raise", 16'(raise), 16'(i < 2));
            check("cmd set", 16'(cset), 16'(i == 2));
            put(16'h447f, 16'h0000, 16'h0100);
            check("lower", 16'(lower), 16'(i < 2));
            put(16'he47f, 16'h0000, 16'h0100);
            check("raise or lower", 16'(raise | lower), 16'h0000);
        end
    endtask
    task automatic t_ignore();
        put(16'h177f, 16'h5001, 16'h0100);
        check("pulse", 16'(pulse), 16'h0001);
        check("drive set", 16'(dset), 16'h0001);
        check("sign of life", 16'(sol), 16'h0005);
        put(16'h047f, 16'haffe, 16'h0100);
        check("drive set", 16'(dset), 16'h0002);
        check("sign of life", 16'(sol), 16'h000a);
        put(16'h007e, 16'h3003, 16'h0100);
        check("drive set", 16'(dset), 16'h0002);
        check("state", 16'(st), 16'(drive_ctrl_pkg::ST_RUN));
        check("accepted", 16'(acc), 16'h0000);
    endtask
    task automatic t_stops();
        put(16'h047e, 16'h0000, 16'h0100);
        check("state", 16'(st), 16'(drive_ctrl_pkg::ST_RAMP_DOWN));
        @(posedge clk) at_zero <= 1'b1;
        wait_cyc(4);
        check("contactor", 16'(cont), 16'h0000);
        put(16'h047b, 16'h0000, 16'h0100);
        check("state", 16'(st), 16'(drive_ctrl_pkg::ST_INHIBIT));
        @(posedge clk) at_zero <= 1'b0;
        put(16'h047e, 16'h0000, 16'h0100);
        put(16'h047f, 16'h0000, 16'h0100);
        check("state", 16'(st), 16'(drive_ctrl_pkg::ST_RUN));
        put(16'h0479, 16'h0000, 16'h0100);
        check("state", 16'(st), 16'(drive_ctrl_pkg::ST_INHIBIT));
        put(16'h047a, 16'h0000, 16'h0100);
        put(16'h047f, 16'h0000, 16'h0100);
        check("state", 16'(st), 16'(drive_ctrl_pkg::ST_RUN));
        put(16'h047b, 16'h0000, 16'h0100);
        check("state", 16'(st), 16'(drive_ctrl_pkg::ST_QUICK));
        check("ramp input", rsp, 16'h0000);
        @(posedge clk) coast_b <= 1'b0;
        wait_cyc(5);
        check("pulse", 16'(pulse), 16'h0000);
    endtask
    // ********
    // Main sequence and watchdog
    // ********
    initial begin
        rst_b = 1'b0;
        coast_b = 1'b1;
        ack_b = 1'b0;
        ack_c = 1'b0;
        at_zero = 1'b0;
        tg = 10'h001;
        err_count = 0;
        total_checks = 0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        wait_cyc(1);
        check("rfg ctrl", 16'(rfg), 16'h0003);
        check("request", 16'(req), 16'h0001);
        t_switch_on();
        t_ramp_gen();
        t_fault_ack();
        t_pot_sets();
        t_ignore();
        t_stops();
        wrap_up();
    end
    // A hang shows as a mismatch rather than a silent stop
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        wrap_up();
    end
endmodule // drive_control_word_decoder_tb_top
`default_nettype wire
